// >>> spindle_defs.svh
/*
  Constants of the spindle speed control block: register offsets, field
  positions, reset values and timing counts.
  Assumes a 25 MHz system clock and a 32-bit AHB-Lite register bus.
*/
`ifndef SPINDLE_DEFS_SVH
`define SPINDLE_DEFS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS        40
`define DEBOUNCE_TIME_NS     1000000
`define DEBOUNCE_CYCLES      (`DEBOUNCE_TIME_NS / `CLK_PERIOD_NS)
`define RAMP_TICK_TIME_NS    1000000
`define RAMP_TICK_CYCLES     (`RAMP_TICK_TIME_NS / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Speed limits, in units of 200 per minute
// ----------------------------------------------------------------------
`define SPEED_MIN_UNITS      10'h005
`define SPEED_HIGH_LIMIT     10'h190
`define SPEED_LOW_LIMIT      10'h12C

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ADDR_CONFIG          8'h00
`define ADDR_MAX_SPEED       8'h04
`define ADDR_ACCEL           8'h08
`define ADDR_REACH           8'h0C
`define ADDR_PRESET0         8'h10
`define ADDR_STATUS          8'h20
`define ADDR_SPEED           8'h24
`define ADDR_INT_STATUS      8'h28
`define ADDR_INT_MASK        8'h2C

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define CFG_ERR_INV_BIT      0
`define CFG_PANEL_AUTO_BIT   1
`define CFG_PRESET_SRC_BIT   2
`define CFG_LOW_VARIANT_BIT  3
`define CONFIG_RESET         4'h0
`define MAX_SPEED_RESET      10'h190
`define ACCEL_RESET          8'h01
`define REACH_RESET          8'h05
`define PRESET0_RESET        10'h032
`define PRESET1_RESET        10'h064
`define PRESET2_RESET        10'h0C8
`define PRESET3_RESET        10'h190
`define INT_ERROR_BIT        0
`define INT_REACHED_BIT      1
`define INT_STOPPED_BIT      2

`endif

// >>> spindle_pkg.sv
/*
  Types shared by the spindle speed control block.
  Assumes nothing of its surroundings.
*/
package spindle_pkg;

  typedef logic [9:0] speed_t;

  // Gray order along stopped, ramping, at speed, braking.
  typedef enum logic [1:0] {
    MS_STOPPED  = 2'b00,
    MS_RAMP     = 2'b01,
    MS_AT_SPEED = 2'b11,
    MS_BRAKING  = 2'b10
  } motion_state_e;

endpackage : spindle_pkg

// >>> input_debounce.sv
/*
  Synchroniser and debouncer for a vector of switched inputs.
  Assumes every raw input is asynchronous to clk and may bounce.
*/
`timescale 1ns/1ps

module input_debounce #(
  parameter int W      = 1,
  parameter int CYCLES = 25000
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] raw_in,
  output logic      [W-1:0] clean_out
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [W-1:0] sync1_reg;
  logic [W-1:0] sync2_reg;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= raw_in;
      sync2_reg <= sync1_reg;
    end
  end

  // ----------------------------------------------------------------------
  // One stability counter per input
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic [CW-1:0] cnt_reg;
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        cnt_reg      <= '0;
        clean_out[i] <= 1'b0;
      end else if (sync2_reg[i] == clean_out[i]) begin
        cnt_reg <= '0;
      end else if (cnt_reg == LAST) begin
        cnt_reg      <= '0;
        clean_out[i] <= sync2_reg[i];
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

endmodule : input_debounce

// >>> spindle_speed_control.sv
/*
  Spindle speed control: manual/auto mode, run, direction, commanded speed,
  speed ramp, error latch and an AHB-Lite register slave.
  Assumes panel buttons and controller inputs are raw switch levels, high when
  closed, and that error_detect and error_code come from logic on clk.
*/
`timescale 1ns/1ps
`include "spindle_defs.svh"

module spindle_speed_control
  import spindle_pkg::*;
#(
  parameter int DEBOUNCE_CYCLES  = `DEBOUNCE_CYCLES,
  parameter int RAMP_TICK_CYCLES = `RAMP_TICK_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic        btn_mode,
  input  wire logic        btn_direction,
  input  wire logic        btn_run_stop,
  input  wire logic        btn_speed_up,
  input  wire logic        btn_speed_down,
  input  wire logic        direction_input,
  input  wire logic        start_input,
  input  wire logic        speed_step_pulse,
  input  wire logic        error_release_input,
  input  wire logic        preset_select_low,
  input  wire logic        preset_select_high,
  input  wire logic        step_up_down_input,
  input  wire logic        error_detect,
  input  wire logic [3:0]  error_code_in,
  output logic             auto_mode,
  output logic             start_led,
  output logic             forward_rotation,
  output logic             reverse_rotation,
  output logic             rotating_out,
  output logic             error_out,
  output logic             speed_reached,
  output logic      [9:0]  speed_display,
  output logic      [3:0]  error_code,
  output logic             irq
);

  // ----------------------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------------------
  logic [11:0] raw_bus;
  logic [11:0] db;
  logic [11:0] db_prev_reg;
  wire  [11:0] rise = db & ~db_prev_reg;
  wire  [11:0] fall = ~db & db_prev_reg;

  assign raw_bus = {step_up_down_input, preset_select_high, preset_select_low, error_release_input,
                    speed_step_pulse, start_input, direction_input, btn_speed_down, btn_speed_up,
                    btn_run_stop, btn_direction, btn_mode};

  input_debounce #(.W(12), .CYCLES(DEBOUNCE_CYCLES)) u_debounce (
    .clk       (clk),
    .reset_n   (reset_n),
    .raw_in    (raw_bus),
    .clean_out (db)
  );

  always_ff @(posedge clk) begin
    if (!reset_n) db_prev_reg <= 12'h000;
    else          db_prev_reg <= db;
  end

  // ----------------------------------------------------------------------
  // Registers and their next values
  // ----------------------------------------------------------------------
  logic [3:0]    config_reg;
  speed_t        max_speed_reg;
  logic [7:0]    accel_reg;
  logic [7:0]    reach_reg;
  speed_t        preset_reg [4];
  logic [2:0]    int_status_reg;
  logic [2:0]    int_mask_reg;
  logic          auto_reg;
  logic          dir_reg;
  logic          run_reg;
  logic          error_reg;
  logic [3:0]    error_code_reg;
  speed_t        panel_speed_reg;
  speed_t        pulse_speed_reg;
  speed_t        actual_reg;
  logic [14:0]   tick_cnt_reg;
  logic [7:0]    accel_cnt_reg;
  motion_state_e state_reg;
  motion_state_e state_next;
  logic          wr_pend_reg;
  logic [7:0]    wr_addr_reg;
  logic [31:0]   rdata_reg;

  // ----------------------------------------------------------------------
  // Commanded speed
  // ----------------------------------------------------------------------
  wire    err_inv      = config_reg[`CFG_ERR_INV_BIT];
  wire    panel_auto   = config_reg[`CFG_PANEL_AUTO_BIT];
  wire    preset_src   = config_reg[`CFG_PRESET_SRC_BIT];
  wire    low_variant  = config_reg[`CFG_LOW_VARIANT_BIT];
  wire    eff_reverse  = auto_reg ? db[5] : dir_reg;
  wire    eff_run      = (auto_reg ? db[6] : run_reg) & ~error_reg;
  wire    ext_speed    = auto_reg & ~panel_auto;
  wire    [1:0] sel    = {db[10], db[9]};
  speed_t variant_lim;
  speed_t cap_lim;
  speed_t limit;
  speed_t source_speed;
  speed_t commanded;
  speed_t target;

  // The floor wins over a cap written below it, so the range always holds.
  assign variant_lim  = low_variant ? `SPEED_LOW_LIMIT : `SPEED_HIGH_LIMIT;
  assign cap_lim      = (max_speed_reg < variant_lim) ? max_speed_reg : variant_lim;
  assign limit        = (cap_lim < `SPEED_MIN_UNITS) ? `SPEED_MIN_UNITS : cap_lim;
  assign source_speed = !ext_speed ? panel_speed_reg : (preset_src ? preset_reg[sel] : pulse_speed_reg);
  assign commanded    = (source_speed > limit) ? limit :
                        ((source_speed < `SPEED_MIN_UNITS) ? `SPEED_MIN_UNITS : source_speed);
  assign target       = eff_run ? commanded : 10'h000;

  // Steps saturate so the stored values never wrap.
  wire    panel_up   = ~auto_reg & rise[3] & (panel_speed_reg < limit);
  wire    panel_dn   = ~auto_reg & rise[4] & (panel_speed_reg > `SPEED_MIN_UNITS);
  wire    pulse_ev   = ext_speed & ~preset_src & rise[7];
  wire    pulse_up   = pulse_ev & db[11] & (pulse_speed_reg < limit);
  wire    pulse_dn   = pulse_ev & ~db[11] & (pulse_speed_reg > `SPEED_MIN_UNITS);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      auto_reg        <= 1'b0;
      dir_reg         <= 1'b0;
      run_reg         <= 1'b0;
      panel_speed_reg <= `SPEED_MIN_UNITS;
      pulse_speed_reg <= `SPEED_MIN_UNITS;
    end else begin
      if (rise[0]) auto_reg <= ~auto_reg;
      if (!auto_reg && rise[1]) dir_reg <= ~dir_reg;
      // A latched error forces a stop, so in manual mode the operator must press run again after release.
      if (error_reg) run_reg <= 1'b0;
      else if (!auto_reg && rise[2]) run_reg <= ~run_reg;
      if (panel_up) panel_speed_reg <= panel_speed_reg + 10'h001;
      else if (panel_dn) panel_speed_reg <= panel_speed_reg - 10'h001;
      if (pulse_up) pulse_speed_reg <= pulse_speed_reg + 10'h001;
      else if (pulse_dn) pulse_speed_reg <= pulse_speed_reg - 10'h001;
    end
  end

  // ----------------------------------------------------------------------
  // Error latch
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      error_reg      <= 1'b0;
      error_code_reg <= 4'h0;
    end else if (error_detect) begin
      error_reg      <= 1'b1;
      error_code_reg <= error_code_in;
    end else if (fall[8]) begin
      error_reg      <= 1'b0;
      error_code_reg <= 4'h0;
    end
  end

  // ----------------------------------------------------------------------
  // Speed ramp
  // ----------------------------------------------------------------------
  localparam logic [14:0] TICK_LAST = 15'(RAMP_TICK_CYCLES - 1);
  wire tick      = (tick_cnt_reg == TICK_LAST);
  wire ramp_step = tick & (accel_cnt_reg >= accel_reg);
  wire [10:0] diff_up = {1'b0, actual_reg} - {1'b0, commanded};
  wire [10:0] diff_dn = {1'b0, commanded} - {1'b0, actual_reg};
  wire [9:0]  gap     = (actual_reg > commanded) ? diff_up[9:0] : diff_dn[9:0];

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tick_cnt_reg  <= 15'h0000;
      accel_cnt_reg <= 8'h00;
      actual_reg    <= 10'h000;
    end else begin
      tick_cnt_reg <= tick ? 15'h0000 : tick_cnt_reg + 15'h0001;
      if (ramp_step || actual_reg == target) accel_cnt_reg <= 8'h00;
      else if (tick) accel_cnt_reg <= accel_cnt_reg + 8'h01;
      if (ramp_step && actual_reg < target) actual_reg <= actual_reg + 10'h001;
      else if (ramp_step && actual_reg > target) actual_reg <= actual_reg - 10'h001;
    end
  end

  always_comb begin
    if (actual_reg == 10'h000 && target == 10'h000) state_next = MS_STOPPED;
    else if (actual_reg > target)                   state_next = MS_BRAKING;
    else if (actual_reg == target)                  state_next = MS_AT_SPEED;
    else                                            state_next = MS_RAMP;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) state_reg <= MS_STOPPED;
    else          state_reg <= state_next;
  end

  assign auto_mode        = auto_reg;
  assign start_led        = eff_run;
  assign forward_rotation = ~eff_reverse;
  assign reverse_rotation = eff_reverse;
  assign rotating_out     = (state_reg != MS_STOPPED);
  assign error_out        = error_reg ^ err_inv;
  assign speed_reached    = eff_run & ({2'b00, reach_reg} >= gap);
  assign speed_display    = actual_reg;
  assign error_code       = error_code_reg;

  // ----------------------------------------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------------------------------------
  wire        accept   = hsel & hready & htrans[1];
  wire [7:0]  raddr    = haddr[7:0];
  wire        rd_int   = accept & ~hwrite & (raddr == `ADDR_INT_STATUS) & (haddr[31:8] == 24'h000000);
  wire        wr_cfg   = wr_pend_reg & (wr_addr_reg == `ADDR_CONFIG);
  wire        wr_max   = wr_pend_reg & (wr_addr_reg == `ADDR_MAX_SPEED);
  wire        wr_acc   = wr_pend_reg & (wr_addr_reg == `ADDR_ACCEL);
  wire        wr_rch   = wr_pend_reg & (wr_addr_reg == `ADDR_REACH);
  wire        wr_pre   = wr_pend_reg & (wr_addr_reg[7:4] == `ADDR_PRESET0 >> 4);
  wire        wr_msk   = wr_pend_reg & (wr_addr_reg == `ADDR_INT_MASK);
  wire [31:0] status_w = {6'h00, actual_reg, 4'h0, error_code_reg, 2'b00, error_reg,
                          speed_reached, rotating_out, eff_reverse, eff_run, auto_reg};
  wire [31:0] read_w   = (haddr[31:8] != 24'h000000)     ? 32'h0000_0000 :
                         (raddr == `ADDR_CONFIG)         ? {28'h0000000, config_reg} :
                         (raddr == `ADDR_MAX_SPEED)      ? {22'h000000, max_speed_reg} :
                         (raddr == `ADDR_ACCEL)          ? {24'h000000, accel_reg} :
                         (raddr == `ADDR_REACH)          ? {24'h000000, reach_reg} :
                         (raddr[7:4] == `ADDR_PRESET0 >> 4 && raddr[1:0] == 2'b00) ?
                                                           {22'h000000, preset_reg[raddr[3:2]]} :
                         (raddr == `ADDR_STATUS)         ? status_w :
                         (raddr == `ADDR_SPEED)          ? {22'h000000, commanded} :
                         (raddr == `ADDR_INT_STATUS)     ? {29'h00000000, int_status_reg} :
                         (raddr == `ADDR_INT_MASK)       ? {29'h00000000, int_mask_reg} : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rdata_reg   <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= accept & hwrite & (haddr[31:8] == 24'h000000);
      wr_addr_reg <= raddr;
      if (accept && !hwrite) rdata_reg <= read_w;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      config_reg    <= `CONFIG_RESET;
      max_speed_reg <= `MAX_SPEED_RESET;
      accel_reg     <= `ACCEL_RESET;
      reach_reg     <= `REACH_RESET;
      int_mask_reg  <= 3'h0;
      preset_reg[0] <= `PRESET0_RESET;
      preset_reg[1] <= `PRESET1_RESET;
      preset_reg[2] <= `PRESET2_RESET;
      preset_reg[3] <= `PRESET3_RESET;
    end else begin
      if (wr_cfg) config_reg <= hwdata[3:0];
      if (wr_max) max_speed_reg <= hwdata[9:0];
      if (wr_acc) accel_reg <= hwdata[7:0];
      if (wr_rch) reach_reg <= hwdata[7:0];
      if (wr_msk) int_mask_reg <= hwdata[2:0];
      if (wr_pre) preset_reg[wr_addr_reg[3:2]] <= hwdata[9:0];
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts: read clears, a new event in the same cycle survives
  // ----------------------------------------------------------------------
  logic reached_prev_reg;
  logic error_prev_reg;
  wire [2:0] events = {rotating_out & (state_next == MS_STOPPED),
                       speed_reached & ~reached_prev_reg, error_reg & ~error_prev_reg};

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      int_status_reg   <= 3'h0;
      reached_prev_reg <= 1'b0;
      error_prev_reg   <= 1'b0;
    end else begin
      int_status_reg   <= (rd_int ? 3'h0 : int_status_reg) | events;
      reached_prev_reg <= speed_reached;
      error_prev_reg   <= error_reg;
    end
  end

  assign irq       = |(int_status_reg & int_mask_reg);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_speed_range;
    @(posedge clk) disable iff (!reset_n)
      commanded >= `SPEED_MIN_UNITS && commanded <= variant_lim;
  endproperty
  a_speed_range: assert property (p_speed_range) else $error("commanded speed out of range");

  property p_speed_cap;
    @(posedge clk) disable iff (!reset_n)
      (max_speed_reg >= `SPEED_MIN_UNITS) |-> commanded <= max_speed_reg;
  endproperty
  a_speed_cap: assert property (p_speed_cap) else $error("commanded speed above cap");

  property p_pulse_up;
    @(posedge clk) disable iff (!reset_n)
      (pulse_ev && db[11] && pulse_speed_reg < limit) |=> pulse_speed_reg == $past(pulse_speed_reg) + 10'h001;
  endproperty
  a_pulse_up: assert property (p_pulse_up) else $error("step pulse did not raise speed");

  property p_pulse_down;
    @(posedge clk) disable iff (!reset_n)
      (pulse_ev && !db[11] && pulse_speed_reg > `SPEED_MIN_UNITS) |=>
        pulse_speed_reg == $past(pulse_speed_reg) - 10'h001;
  endproperty
  a_pulse_down: assert property (p_pulse_down) else $error("step pulse did not lower speed");

  property p_auto_run;
    @(posedge clk) disable iff (!reset_n)
      (auto_reg && !error_reg) |-> start_led == db[6];
  endproperty
  a_auto_run: assert property (p_auto_run) else $error("run indicator differs from start input");

  property p_auto_dir;
    @(posedge clk) disable iff (!reset_n)
      auto_reg |-> (reverse_rotation == db[5] && forward_rotation == !db[5]);
  endproperty
  a_auto_dir: assert property (p_auto_dir) else $error("direction differs from input");

  property p_manual_dir;
    @(posedge clk) disable iff (!reset_n)
      (!auto_reg && rise[1]) |=> reverse_rotation != $past(reverse_rotation);
  endproperty
  a_manual_dir: assert property (p_manual_dir) else $error("direction button did not toggle");

  property p_release;
    @(posedge clk) disable iff (!reset_n)
      (error_reg && fall[8] && !error_detect) |=> !error_reg && error_code == 4'h0;
  endproperty
  a_release: assert property (p_release) else $error("error not released");

  property p_ramp_rate;
    @(posedge clk) disable iff (!reset_n)
      !tick |=> actual_reg == $past(actual_reg);
  endproperty
  a_ramp_rate: assert property (p_ramp_rate) else $error("speed moved off a ramp tick");

  property p_error_out;
    @(posedge clk) disable iff (!reset_n)
      $rose(error_reg) |-> error_out == !err_inv;
  endproperty
  a_error_out: assert property (p_error_out) else $error("error output has wrong polarity");

  c_auto_run:  cover property (@(posedge clk) disable iff (!reset_n) auto_reg && rotating_out);
  c_reached:   cover property (@(posedge clk) disable iff (!reset_n) $rose(speed_reached));
  c_release:   cover property (@(posedge clk) disable iff (!reset_n) $fell(error_reg));

endmodule : spindle_speed_control

// >>> cnc_model.sv
/*
  Controller model driving the switched auto-mode inputs as plain levels.
  Assumes the bench calls put only after reset and waits out its settle time.
*/
`timescale 1ns/1ps
module cnc_model (
  input  wire logic clk,
  output logic      direction_input,
  output logic      start_input,
  output logic      speed_step_pulse,
  output logic      error_release_input,
  output logic      preset_select_low,
  output logic      preset_select_high,
  output logic      step_up_down_input
);
  initial {step_up_down_input, preset_select_high, preset_select_low, error_release_input,
           speed_step_pulse, start_input, direction_input} = 7'h00;
  // Levels are held long enough for the debouncer, so no step is lost or doubled.
  task automatic put(input logic [6:0] v);
    @(posedge clk);
    {step_up_down_input, preset_select_high, preset_select_low, error_release_input,
     speed_step_pulse, start_input, direction_input} <= v;
    repeat (12) @(posedge clk);
  endtask : put
endmodule : cnc_model

// >>> spindle_speed_control_bench.sv
/*
  Self-checking bench of the spindle speed control block over AHB-Lite.
  Assumes the debounce count 4 and ramp tick 8 set at the instance.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module spindle_speed_control_bench;
  logic clk = 0, reset_n, hsel, hwrite, error_detect;
  logic [31:0] haddr, hwdata, hrdata, r, v;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  error_code_in, error_code;
  logic [4:0]  btn;
  logic hreadyout, hresp, auto_mode, start_led, forward_rotation, reverse_rotation, rotating_out;
  logic error_out, speed_reached, irq, direction_input, start_input, speed_step_pulse;
  logic error_release_input, preset_select_low, preset_select_high, step_up_down_input;
  logic [9:0]  speed_display;
  int failures = 0, compares = 0;
  wire hready = hreadyout;
  wire btn_mode = btn[0];
  wire btn_direction = btn[1];
  wire btn_run_stop = btn[2];
  wire btn_speed_up = btn[3];
  wire btn_speed_down = btn[4];
  always #20 clk = ~clk;
  spindle_speed_control #(.DEBOUNCE_CYCLES(4), .RAMP_TICK_CYCLES(8)) i_spindle_speed_control (
    .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .btn_mode(btn_mode), .btn_direction(btn_direction), .btn_run_stop(btn_run_stop),
    .btn_speed_up(btn_speed_up), .btn_speed_down(btn_speed_down), .direction_input(direction_input),
    .start_input(start_input), .speed_step_pulse(speed_step_pulse), .error_release_input(error_release_input),
    .preset_select_low(preset_select_low), .preset_select_high(preset_select_high),
    .step_up_down_input(step_up_down_input), .error_detect(error_detect), .error_code_in(error_code_in),
    .auto_mode(auto_mode), .start_led(start_led), .forward_rotation(forward_rotation),
    .reverse_rotation(reverse_rotation), .rotating_out(rotating_out), .error_out(error_out),
    .speed_reached(speed_reached), .speed_display(speed_display), .error_code(error_code), .irq(irq));
  cnc_model i_cnc_model (.clk(clk), .direction_input(direction_input), .start_input(start_input),
    .speed_step_pulse(speed_step_pulse), .error_release_input(error_release_input),
    .preset_select_low(preset_select_low), .preset_select_high(preset_select_high),
    .step_up_down_input(step_up_down_input));
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h000000, a};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 0; htrans <= 2'h0; hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
    repeat (2) @(posedge clk);
  endtask : bus
  task automatic press(input int i);
    btn[i] <= 1; repeat (12) @(posedge clk);
    btn[i] <= 0; repeat (12) @(posedge clk);
  endtask : press
  task automatic end_sim;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  initial begin
    #(40 * 20000); failures++; end_sim();
  end
  initial begin
    {reset_n, hsel, hwrite, error_detect, haddr, hwdata, htrans, error_code_in, btn} = '0;
    hsize = 3'h2;
    repeat (4) @(posedge clk);
    reset_n <= 1;
    @(posedge clk);
    `CHK({hreadyout, hresp}, 2'b10)
    bus(0, 8'h04, 0); `CHK(r, 32'h00000190)
    bus(0, 8'h40, 0); `CHK(r, 32'h00000000)
    `CHK(forward_rotation, 1'b1)
    press(1); `CHK(reverse_rotation, 1'b1)
    press(2); `CHK(start_led, 1'b1)
    press(2); `CHK(start_led, 1'b0)
    press(3); press(3); press(4); bus(0, 8'h24, 0); `CHK(r, 32'h00000006)
    press(0); `CHK(auto_mode, 1'b1)
    $display("test manual done");
    i_cnc_model.put(7'h03); `CHK({reverse_rotation, start_led}, 2'h3)
    i_cnc_model.put(7'h00); `CHK({forward_rotation, start_led}, 2'h2)
    bus(0, 8'h24, 0); v = r;
    i_cnc_model.put(7'h44); i_cnc_model.put(7'h40);
    bus(0, 8'h24, 0); `CHK(r, v + 1)
    i_cnc_model.put(7'h04); i_cnc_model.put(7'h00);
    bus(0, 8'h24, 0); `CHK(r, v)
    i_cnc_model.put(7'h02); repeat (200) @(posedge clk);
    `CHK({rotating_out, speed_reached, speed_display}, 12'hC05)
    bus(0, 8'h20, 0); `CHK(r, 32'h0005001B)
    i_cnc_model.put(7'h00); repeat (200) @(posedge clk);
    `CHK({rotating_out, speed_display}, 11'h000)
    bus(1, 8'h00, 32'h2); bus(0, 8'h24, 0); `CHK(r, 32'h00000006)
    bus(1, 8'h00, 32'h4);
    for (int s = 0; s < 4; s++) begin
      i_cnc_model.put(7'(s << 4));
      bus(0, 8'h24, 0); `CHK(r[9:0], s == 0 ? 10'h032 : s == 1 ? 10'h064 : s == 2 ? 10'h0C8 : 10'h190)
    end
    bus(1, 8'h1C, 32'h3FF); bus(0, 8'h24, 0); `CHK(r[9:0], 10'h190)
    bus(1, 8'h04, 32'h0C8); bus(0, 8'h24, 0); `CHK(r[9:0], 10'h0C8)
    bus(1, 8'h04, 32'h3FF); bus(1, 8'h00, 32'hC); bus(1, 8'h1C, 32'h3FF);
    bus(0, 8'h24, 0); `CHK(r[9:0], 10'h12C)
    bus(1, 8'h1C, 32'h001); bus(0, 8'h24, 0); `CHK(r[9:0], 10'h005)
    $display("test speed done");
    bus(1, 8'h2C, 32'h1); bus(0, 8'h28, 0);
    error_code_in <= 4'hA; error_detect <= 1; @(posedge clk);
    error_detect <= 0; repeat (3) @(posedge clk);
    `CHK({irq, error_out, error_code}, 6'h3A)
    bus(0, 8'h28, 0); `CHK(r[0], 1'b1)
    `CHK(irq, 1'b0)
    bus(1, 8'h00, 32'h1); `CHK(error_out, 1'b0)
    i_cnc_model.put(7'h08); `CHK(error_code, 4'hA)
    i_cnc_model.put(7'h00); `CHK(error_code, 4'h0)
    $display("test error done");
    end_sim();
  end
endmodule : spindle_speed_control_bench
